// ---- hw/jid_pkg.sv ----
// package: instruction codes, field layouts and pin counts for the tap instruction decoder
package jid_pkg;
   // ----------------------------------------
   // instruction register
   // ----------------------------------------
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_SAMPLE = 4'h1;
   localparam logic [3:0] OP_IDCODE = 4'h2;
   localparam logic [3:0] OP_HIGHZ = 4'h3;
   localparam logic [3:0] OP_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE_PAT = 4'h1;
   // ----------------------------------------
   // identification value layout
   // ----------------------------------------
   localparam int ID_WIDTH = 32;
   localparam logic [3:0] ID_VERSION = 4'h0;         // arbitrary value
   localparam logic [15:0] ID_PART = 16'h1234;       // arbitrary value
   localparam logic [10:0] ID_MAKER = 11'h055;       // arbitrary value
   localparam logic ID_MARKER = 1'b1;
   // ----------------------------------------
   // boundary cells and tap states
   // ----------------------------------------
   localparam int BSR_PINS_IN = 4;
   localparam int BSR_PINS_OUT = 4;
   localparam int BSR_LEN = BSR_PINS_IN + 2 * BSR_PINS_OUT;
   localparam int TLR_TMS_COUNT = 5;
   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
      ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
   } jid_state_t;
   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0, SEL_BSR = 2'h1, SEL_ID = 2'h2
   } jid_sel_t;
endpackage

// ---- hw/jid_sync.sv ----
// two flop synchroniser for pin inputs
`timescale 1ns/100ps
module jid_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rst_val,
   input wire logic din,
   output logic dout
);
   logic stage1;
   // reset value fixed at zero in every instance; the rst_val tie at the instance is not used
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
   logic unused_rst_val;
   assign unused_rst_val = rst_val;
endmodule

// ---- hw/jid_tap_fsm.sv ----
// tap controller state machine, advanced on detected tck rising edges
`timescale 1ns/100ps
module jid_tap_fsm (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck_rise,
   input wire logic tms,
   input wire logic trst_sync_b,
   output jid_pkg::jid_state_t state
);
   jid_pkg::jid_state_t next_state;
   always_comb begin
      next_state = state;
      case (state)
         jid_pkg::ST_TLR: next_state = tms ? jid_pkg::ST_TLR : jid_pkg::ST_RTI;
         jid_pkg::ST_RTI: next_state = tms ? jid_pkg::ST_SEL_DR : jid_pkg::ST_RTI;
         jid_pkg::ST_SEL_DR: next_state = tms ? jid_pkg::ST_SEL_IR : jid_pkg::ST_CAP_DR;
         jid_pkg::ST_CAP_DR: next_state = tms ? jid_pkg::ST_EX1_DR : jid_pkg::ST_SH_DR;
         jid_pkg::ST_SH_DR: next_state = tms ? jid_pkg::ST_EX1_DR : jid_pkg::ST_SH_DR;
         jid_pkg::ST_EX1_DR: next_state = tms ? jid_pkg::ST_UPD_DR : jid_pkg::ST_PA_DR;
         jid_pkg::ST_PA_DR: next_state = tms ? jid_pkg::ST_EX2_DR : jid_pkg::ST_PA_DR;
         jid_pkg::ST_EX2_DR: next_state = tms ? jid_pkg::ST_UPD_DR : jid_pkg::ST_SH_DR;
         jid_pkg::ST_UPD_DR: next_state = tms ? jid_pkg::ST_SEL_DR : jid_pkg::ST_RTI;
         jid_pkg::ST_SEL_IR: next_state = tms ? jid_pkg::ST_TLR : jid_pkg::ST_CAP_IR;
         jid_pkg::ST_CAP_IR: next_state = tms ? jid_pkg::ST_EX1_IR : jid_pkg::ST_SH_IR;
         jid_pkg::ST_SH_IR: next_state = tms ? jid_pkg::ST_EX1_IR : jid_pkg::ST_SH_IR;
         jid_pkg::ST_EX1_IR: next_state = tms ? jid_pkg::ST_UPD_IR : jid_pkg::ST_PA_IR;
         jid_pkg::ST_PA_IR: next_state = tms ? jid_pkg::ST_EX2_IR : jid_pkg::ST_PA_IR;
         jid_pkg::ST_EX2_IR: next_state = tms ? jid_pkg::ST_UPD_IR : jid_pkg::ST_SH_IR;
         jid_pkg::ST_UPD_IR: next_state = tms ? jid_pkg::ST_SEL_DR : jid_pkg::ST_RTI;
         default: next_state = jid_pkg::ST_TLR;
      endcase
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= jid_pkg::ST_TLR;
      end else if (!trst_sync_b) begin
         state <= jid_pkg::ST_TLR;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end
endmodule

// ---- hw/jid_decoder.sv ----
// tap instruction register, decoding and test data registers
// Contract
// - four-bit instruction register holding sixteen possible instruction codes
// - instruction bits shift in from tdi only in shift-ir
// - decoded instruction picks the one data register between tdi and tdo
// - unselected data registers stay idle and leave normal operation alone
// - code 0x00 enters external test with boundary register selected
// - under external test, cells drive held outputs and capture inputs
// - code 0x02 selects 32-bit identification register, device runs normally
// - reset, trst or test-logic-reset selects the identification register
// - code 0x01 selects boundary register and samples functional pin values
// - code 0x03 forces every device output to high impedance
// - high-impedance code selects bypass; shifting leaves outputs forced off
// - code 0x0F selects one-bit bypass with normal operation
// - bypass stage loads zero on tck rise in capture-dr
// - capture-ir loads a fixed pattern ending in binary 01
// - shifted instruction becomes current on falling tck in update-ir
// - identification holds version, part, maker code and a one in bit 0
`timescale 1ns/100ps
module jid_decoder (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_b,
   output logic tdo,
   output logic tdo_oe,
   input wire logic [3:0] func_out,
   input wire logic [3:0] func_oe,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe,
   output logic [3:0] core_in,
   output logic [3:0] cur_instr
);
   // ----------------------------------------
   // pin synchronisers and tck edges
   // ----------------------------------------
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_s_b;
   logic tck_d;
   jid_sync u_sync_tck (.clk(clk), .rst_b(rst_b), .rst_val(1'b0), .din(tck), .dout(tck_s));
   jid_sync u_sync_tms (.clk(clk), .rst_b(rst_b), .rst_val(1'b0), .din(tms), .dout(tms_s));
   jid_sync u_sync_tdi (.clk(clk), .rst_b(rst_b), .rst_val(1'b0), .din(tdi), .dout(tdi_s));
   jid_sync u_sync_trst (.clk(clk), .rst_b(rst_b), .rst_val(1'b0), .din(trst_b), .dout(trst_s_b));
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tck_d <= 1'b0;
      end else begin
         tck_d <= tck_s;
      end
   end
   wire tck_rise = tck_s & ~tck_d;
   wire tck_fall = ~tck_s & tck_d;
   // ----------------------------------------
   // tap state machine
   // ----------------------------------------
   jid_pkg::jid_state_t state;
   jid_tap_fsm u_fsm (
      .clk(clk),
      .rst_b(rst_b),
      .tck_rise(tck_rise),
      .tms(tms_s),
      .trst_sync_b(trst_s_b),
      .state(state)
   );
   wire in_tlr = (state == jid_pkg::ST_TLR) | ~trst_s_b;
   wire cap_ir = (state == jid_pkg::ST_CAP_IR);
   wire sh_ir = (state == jid_pkg::ST_SH_IR);
   wire upd_ir = (state == jid_pkg::ST_UPD_IR);
   wire cap_dr = (state == jid_pkg::ST_CAP_DR);
   wire sh_dr = (state == jid_pkg::ST_SH_DR);
   wire upd_dr = (state == jid_pkg::ST_UPD_DR);
   // ----------------------------------------
   // instruction shift stage and latch
   // ----------------------------------------
   logic [jid_pkg::IR_WIDTH-1:0] ir_shift;
   logic [jid_pkg::IR_WIDTH-1:0] ir_latch;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_shift <= jid_pkg::IR_CAPTURE_PAT;
      end else if (tck_rise && cap_ir) begin
         ir_shift <= jid_pkg::IR_CAPTURE_PAT;
      end else if (tck_rise && sh_ir) begin
         ir_shift <= {tdi_s, ir_shift[3:1]};
      end
   end
   // reset lands on idcode so a data scan reads id straight away
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_latch <= jid_pkg::OP_IDCODE;
      end else if (in_tlr) begin
         ir_latch <= jid_pkg::OP_IDCODE;
      end else if (tck_fall && upd_ir) begin
         ir_latch <= ir_shift;
      end
   end
   assign cur_instr = ir_latch;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire is_extest = (ir_latch == jid_pkg::OP_EXTEST);
   wire is_sample = (ir_latch == jid_pkg::OP_SAMPLE);
   wire is_idcode = (ir_latch == jid_pkg::OP_IDCODE);
   wire is_highz = (ir_latch == jid_pkg::OP_HIGHZ);
   // everything else, 0x0F included, is bypass
   jid_pkg::jid_sel_t sel;
   assign sel = (is_extest | is_sample) ? jid_pkg::SEL_BSR :
                is_idcode ? jid_pkg::SEL_ID : jid_pkg::SEL_BYPASS;
   wire sel_bsr = (sel == jid_pkg::SEL_BSR);
   wire sel_id = (sel == jid_pkg::SEL_ID);
   wire sel_byp = (sel == jid_pkg::SEL_BYPASS);
   // ----------------------------------------
   // bypass stage
   // ----------------------------------------
   logic byp;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         byp <= 1'b0;
      end else if (tck_rise && sel_byp && cap_dr) begin
         byp <= 1'b0;
      end else if (tck_rise && sel_byp && sh_dr) begin
         byp <= tdi_s;
      end
   end
   // ----------------------------------------
   // identification register
   // ----------------------------------------
   wire [31:0] id_value = {jid_pkg::ID_VERSION, jid_pkg::ID_PART, jid_pkg::ID_MAKER, jid_pkg::ID_MARKER};
   logic [jid_pkg::ID_WIDTH-1:0] id_shift;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         id_shift <= 32'h00000000;
      end else if (tck_rise && sel_id && cap_dr) begin
         id_shift <= id_value;
      end else if (tck_rise && sel_id && sh_dr) begin
         id_shift <= {tdi_s, id_shift[31:1]};
      end
   end
   // ----------------------------------------
   // boundary register: inputs, output data, output enables
   // ----------------------------------------
   localparam int BL = jid_pkg::BSR_LEN;
   logic [BL-1:0] bsr_shift;
   logic [BL-1:0] bsr_hold;
   wire [BL-1:0] bsr_capture = {func_oe, func_out, pin_in};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bsr_shift <= '0;
      end else if (tck_rise && sel_bsr && cap_dr) begin
         bsr_shift <= bsr_capture;
      end else if (tck_rise && sel_bsr && sh_dr) begin
         bsr_shift <= {tdi_s, bsr_shift[BL-1:1]};
      end
   end
   // update hold stage on falling tck so outputs change away from the capture edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bsr_hold <= '0;
      end else if (tck_fall && sel_bsr && upd_dr) begin
         bsr_hold <= bsr_shift;
      end
   end
   wire [3:0] hold_in = bsr_hold[jid_pkg::BSR_PINS_IN-1:0];
   wire [3:0] hold_out = bsr_hold[jid_pkg::BSR_PINS_IN+jid_pkg::BSR_PINS_OUT-1:jid_pkg::BSR_PINS_IN];
   wire [3:0] hold_oe = bsr_hold[BL-1:jid_pkg::BSR_PINS_IN+jid_pkg::BSR_PINS_OUT];
   // ----------------------------------------
   // pin muxing
   // ----------------------------------------
   logic [3:0] next_pin_out;
   logic [3:0] next_pin_oe;
   logic [3:0] next_core_in;
   always_comb begin
      next_pin_out = func_out;
      next_pin_oe = func_oe;
      next_core_in = pin_in;
      if (is_extest) begin
         next_pin_out = hold_out;
         next_pin_oe = hold_oe;
         next_core_in = hold_in;
      end else if (is_highz) begin
         next_pin_out = 4'h0;
         next_pin_oe = 4'h0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= 4'h0;
         pin_oe <= 4'h0;
         core_in <= 4'h0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         core_in <= next_core_in;
      end
   end
   // ----------------------------------------
   // tdo: changes on falling tck, driven only while shifting
   // ----------------------------------------
   wire dr_bit = sel_id ? id_shift[0] : sel_bsr ? bsr_shift[0] : byp;
   wire next_tdo = sh_ir ? ir_shift[0] : dr_bit;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo <= next_tdo;
         tdo_oe <= sh_ir | sh_dr;
      end
   end
endmodule

// ---- verif/jid_decoder_properties.sv ----
// checker: port-level timing and output relations of the instruction decoder
`timescale 1ns/100ps
module jid_decoder_properties (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_b,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic [3:0] func_out,
   input wire logic [3:0] func_oe,
   input wire logic [3:0] pin_in,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] core_in,
   input wire logic [3:0] cur_instr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // extest and highz are the only codes that take the pins from the core
   wire logic normal = cur_instr != jid_pkg::OP_EXTEST && cur_instr != jid_pkg::OP_HIGHZ;
   highz_oe_a:
      assert property ((cur_instr == jid_pkg::OP_HIGHZ) [*3] |-> pin_oe == 4'h0) else $error("oe on under highz");
   highz_out_a:
      assert property ((cur_instr == jid_pkg::OP_HIGHZ) [*3] |-> pin_out == 4'h0) else $error("data under highz");
   normal_oe_a:
      assert property ((normal && $stable(func_oe)) [*4] |-> pin_oe == func_oe) else $error("oe not core");
   normal_out_a:
      assert property ((normal && $stable(func_out)) [*4] |-> pin_out == func_out) else $error("data not core");
   core_pass_a:
      assert property ((cur_instr != jid_pkg::OP_EXTEST && $stable(pin_in)) [*4] |-> core_in == pin_in)
         else $error("core input not pin");
   trst_id_a:
      assert property ((!trst_b) [*5] |-> cur_instr == jid_pkg::OP_IDCODE) else $error("trst left instr");
   instr_fall_a:
      assert property ($changed(cur_instr) && cur_instr != jid_pkg::OP_IDCODE |-> !tck)
         else $error("instr changed with tck high");
   tdo_fall_a:
      assert property ($changed(tdo) |-> !tck) else $error("tdo changed with tck high");
   tdo_oe_fall_a:
      assert property ($changed(tdo_oe) |-> !tck) else $error("tdo_oe changed with tck high");
endmodule
bind jid_decoder jid_decoder_properties jid_decoder_properties_inst (
   .clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe),
   .func_out(func_out), .func_oe(func_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .core_in(core_in), .cur_instr(cur_instr)
);

// ---- verif/jid_tester.sv ----
// boundary-scan tester model driving the tap pins
`timescale 1ns/100ps
module jid_tester (
   input wire logic clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_b,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_b = 1'b1;
   end
   // tck period 17 clk; stays low between frames
   task automatic tap_bit(input logic m, input logic d, output logic q);
      @(posedge clk);
      tms <= m;
      tdi <= d;
      repeat (8) @(posedge clk);
      q = tdo;
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
   endtask
   // tdi toggles outside shifts so a stale bit is never mistaken for data
   task automatic tms_walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) tap_bit(seq[i], ~tdi, q);
   endtask
   task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      tms_walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         tap_bit(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tms_walk(8'h01, 2);
   endtask
   task automatic pulse_trst();
      @(posedge clk);
      trst_b <= 1'b0;
      repeat (8) @(posedge clk);
      trst_b <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ---- verif/jid_decoder_bench.sv ----
// testbench: instruction load, data paths and pin control of the decoder
`timescale 1ns/100ps
module jid_decoder_bench;
   logic clk, rst_b, tck, tms, tdi, trst_b, tdo, tdo_oe;
   logic [3:0] func_out, func_oe, pin_in, pin_out, pin_oe, core_in, cur_instr;
   logic [31:0] rd;
   int miscompares;
   int cmp_count;
   jid_decoder jid_decoder_inst (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
      .tdo(tdo), .tdo_oe(tdo_oe), .func_out(func_out), .func_oe(func_oe), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .core_in(core_in), .cur_instr(cur_instr));
   jid_tester jid_tester_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic load(input logic [3:0] op);
      jid_tester_inst.scan(1'b1, {28'h0, op}, 4, rd);
      check("ir capture", 32'h1, rd);
      check("cur_instr", op, cur_instr);
   endtask
   task automatic check_normal();
      repeat (6) @(posedge clk);
      check("pin_out", func_out, pin_out);
      check("pin_oe", func_oe, pin_oe);
      check("core_in", pin_in, core_in);
   endtask
   task automatic check_bypass();
      jid_tester_inst.scan(1'b0, 32'hB5, 8, rd);
      check("bypass path", 32'h6A, rd);
   endtask
   task automatic t_idcode();
      check("reset instr", jid_pkg::OP_IDCODE, cur_instr);
      jid_tester_inst.tms_walk(8'h00, 1);
      jid_tester_inst.scan(1'b0, 32'h0, 32, rd);
      check("id", {jid_pkg::ID_VERSION, jid_pkg::ID_PART, jid_pkg::ID_MAKER, jid_pkg::ID_MARKER}, rd);
      check_normal();
   endtask
   // covers bypass and every unassigned code, with the core data moving
   task automatic t_bypass();
      for (int i = 4; i < 16; i++) begin
         @(posedge clk);
         func_out <= i[3:0];
         func_oe <= ~i[3:0];
         load(i[3:0]);
         check_bypass();
         check_normal();
      end
   endtask
   task automatic t_highz();
      load(jid_pkg::OP_HIGHZ);
      repeat (6) @(posedge clk);
      check("highz oe", 4'h0, pin_oe);
      check("highz out", 4'h0, pin_out);
      check_bypass();
      check("highz oe kept", 4'h0, pin_oe);
   endtask
   task automatic t_sample_extest();
      load(jid_pkg::OP_SAMPLE);
      jid_tester_inst.scan(1'b0, 32'hC69, 12, rd);
      check("sample", {20'h0, func_oe, func_out, pin_in}, rd);
      check_normal();
      load(jid_pkg::OP_EXTEST);
      repeat (6) @(posedge clk);
      check("extest out", 4'h6, pin_out);
      check("extest oe", 4'hC, pin_oe);
      check("extest core", 4'h9, core_in);
      @(posedge clk);
      pin_in <= 4'h5;
      jid_tester_inst.scan(1'b0, 32'hC69, 12, rd);
      check("extest capture", 4'h5, rd[3:0]);
   endtask
   task automatic t_resets();
      load(jid_pkg::OP_BYPASS);
      jid_tester_inst.pulse_trst();
      check("trst instr", jid_pkg::OP_IDCODE, cur_instr);
      jid_tester_inst.tms_walk(8'h00, 1);
      load(jid_pkg::OP_HIGHZ);
      jid_tester_inst.tms_walk(8'h1F, jid_pkg::TLR_TMS_COUNT);
      check("tlr instr", jid_pkg::OP_IDCODE, cur_instr);
      check_normal();
      jid_tester_inst.tms_walk(8'h00, 1);
      load(jid_pkg::OP_SAMPLE);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      check("rst instr", jid_pkg::OP_IDCODE, cur_instr);
      check("rst tdo_oe", 1'b0, tdo_oe);
   endtask
   initial begin
      rst_b = 1'b0;
      func_out = 4'hA;
      func_oe = 4'h5;
      pin_in = 4'h3;
      miscompares = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_idcode();
      t_bypass();
      t_highz();
      t_sample_extest();
      t_resets();
      conclude();
   end
   initial begin
      #1000000;
      miscompares++;
      $display("FAIL watchdog expected done seen timeout");
      conclude();
   end
endmodule
